/* i2c_word_slave.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-wire slave giving a master access to 256 words of 16 bits
// Assumes: clk at least 8x faster than scl; user read data valid in the rd_en cycle
// Notes: link logic runs on scl and sda edges, word port on clk
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module i2c_word_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  i2c_link_if.slave link,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [15:0] rd_data,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data
);

  typedef enum logic [4:0] {
    LK_IDLE = 5'h01,
    LK_ADDR = 5'h02,
    LK_PTR = 5'h04,
    LK_WDAT = 5'h08,
    LK_RDAT = 5'h10
  } lk_state_e;

  //////////////////////////////////////////////////////////////////////////
  // link domain registers (scl, sda edges); async clear from rst only
  lk_state_e state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sr_ff;
  logic match_ff;
  logic rw_ff;
  logic [7:0] ptr_ff;
  logic over_ff;
  logic hi_ff;
  logic [7:0] lo_ff;
  logic [15:0] wr_hold_ff;
  logic [7:0] wr_addr_hold_ff;
  logic wr_tgl_ff;
  logic ptr_tgl_ff;
  logic start_tgl_ff;
  logic start_seen_ff;
  logic stop_tgl_ff;
  logic stop_seen_ff;
  logic oe_ff;
  logic [15:0] word_ff;

  // clk domain registers
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] sync3_ff;
  logic rd_en_ff;
  logic [7:0] rd_addr_ff;
  logic [15:0] rd_word_ff;
  logic wr_en_ff;
  logic [7:0] wr_addr_ff;
  logic [15:0] wr_data_ff;

  logic start_pend;
  logic stop_pend;
  logic [7:0] byte_in;
  logic [15:0] tx_word;
  logic [7:0] tx_byte;

  // start/stop flags change three quarters of an scl period before the next rising
  // edge reads them, so a single sample is settled in practice
  assign start_pend = start_tgl_ff ^ start_seen_ff;
  assign stop_pend = stop_tgl_ff ^ stop_seen_ff;
  assign byte_in = {sr_ff[6:0], link.sda};

  //////////////////////////////////////////////////////////////////////////
  // start and stop detection: sda moving while scl is high
  always_ff @(negedge link.sda or posedge rst) begin
    if (rst) begin
      start_tgl_ff <= 1'h0;
    end else if (link.scl) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  always_ff @(posedge link.sda or posedge rst) begin
    if (rst) begin
      stop_tgl_ff <= 1'h0;
    end else if (link.scl) begin
      stop_tgl_ff <= ~stop_tgl_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // protocol state and bit counter, sampled on rising scl
  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      state_ff <= LK_IDLE;
      cnt_ff <= 4'h0;
      start_seen_ff <= 1'h0;
      stop_seen_ff <= 1'h0;
    end else if (start_pend) begin
      start_seen_ff <= start_tgl_ff;
      stop_seen_ff <= stop_tgl_ff;
      state_ff <= LK_ADDR;
      cnt_ff <= 4'h1;
    end else if (stop_pend) begin
      stop_seen_ff <= stop_tgl_ff;
      state_ff <= LK_IDLE;
      cnt_ff <= 4'h0;
    end else if (state_ff != LK_IDLE) begin
      if (cnt_ff != i2c_word_pkg::BIT_ACK) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else begin
        cnt_ff <= 4'h0;
        case (state_ff)
          LK_ADDR: begin
            if (!match_ff) begin
              state_ff <= LK_IDLE;
            end else if (rw_ff == i2c_word_pkg::DIR_READ) begin
              state_ff <= LK_RDAT;
            end else begin
              state_ff <= LK_PTR;
            end
          end
          LK_PTR: state_ff <= LK_WDAT;
          LK_WDAT: state_ff <= LK_WDAT;
          LK_RDAT: begin
            // a nack from the master ends the read
            if (link.sda != i2c_word_pkg::ACK_LEVEL) begin
              state_ff <= LK_IDLE;
            end
          end
          default: state_ff <= LK_IDLE;
        endcase
      end
    end
  end

  // shift register and address decode
  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      sr_ff <= 8'h0;
      match_ff <= 1'h0;
      rw_ff <= 1'h0;
    end else begin
      sr_ff <= byte_in;
      if (!start_pend && state_ff == LK_ADDR
          && cnt_ff == i2c_word_pkg::BIT_LAST) begin
        match_ff <= (byte_in[7:1] == i2c_word_pkg::SLAVE_ADDR);
        rw_ff <= byte_in[0];
      end
    end
  end

  // pointer, byte phase and write capture
  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      ptr_ff <= 8'h0;
      over_ff <= 1'h0;
      hi_ff <= 1'h0;
      lo_ff <= 8'h0;
      wr_hold_ff <= 16'h0;
      wr_addr_hold_ff <= 8'h0;
      wr_tgl_ff <= 1'h0;
      ptr_tgl_ff <= 1'h0;
    end else if (start_pend) begin
      // pointer survives a repeated start so a read picks it up
      hi_ff <= 1'h0;
    end else if (state_ff == LK_PTR && cnt_ff == i2c_word_pkg::BIT_LAST) begin
      ptr_ff <= byte_in;
      over_ff <= 1'h0;
      ptr_tgl_ff <= ~ptr_tgl_ff;
    end else if (state_ff == LK_WDAT && cnt_ff == i2c_word_pkg::BIT_LAST) begin
      if (!hi_ff) begin
        lo_ff <= byte_in;
      end else begin
        wr_hold_ff <= {byte_in, lo_ff};
      end
    end else if (cnt_ff == i2c_word_pkg::BIT_ACK
                 && (state_ff == LK_WDAT
                     || (state_ff == LK_RDAT
                         && link.sda == i2c_word_pkg::ACK_LEVEL))) begin
      hi_ff <= ~hi_ff;
      if (hi_ff) begin
        if (state_ff == LK_WDAT && !over_ff
            && !i2c_word_pkg::READ_ONLY_MAP[ptr_ff]) begin
          wr_addr_hold_ff <= ptr_ff;
          wr_tgl_ff <= ~wr_tgl_ff;
        end
        if (ptr_ff == i2c_word_pkg::TOP_PTR) begin
          over_ff <= 1'h1;
        end else begin
          ptr_ff <= ptr_ff + 8'h1;
          ptr_tgl_ff <= ~ptr_tgl_ff;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sda drive on falling scl: acks and read data
  // no rate setting: everything moves on the master's own edges
  assign tx_word = (cnt_ff == 4'h0 && !hi_ff)
                   ? (over_ff ? i2c_word_pkg::PAST_TOP_WORD : rd_word_ff)
                   : word_ff;
  assign tx_byte = hi_ff ? tx_word[15:8] : tx_word[7:0];

  always_ff @(negedge link.scl or posedge rst) begin
    if (rst) begin
      oe_ff <= 1'h0;
      word_ff <= 16'h0;
    end else begin
      case (state_ff)
        LK_ADDR: oe_ff <= (cnt_ff == i2c_word_pkg::BIT_ACK) && match_ff;
        LK_PTR: oe_ff <= (cnt_ff == i2c_word_pkg::BIT_ACK);
        // data past the top is still acked, then dropped
        LK_WDAT: oe_ff <= (cnt_ff == i2c_word_pkg::BIT_ACK);
        LK_RDAT: begin
          if (cnt_ff == i2c_word_pkg::BIT_ACK) begin
            oe_ff <= 1'h0;
          end else begin
            oe_ff <= ~tx_byte[~cnt_ff[2:0]];
          end
        end
        default: oe_ff <= 1'h0;
      endcase
      // latch the whole word with its low byte so halves match
      if (state_ff == LK_RDAT && cnt_ff == 4'h0 && !hi_ff) begin
        word_ff <= tx_word;
      end
    end
  end

  assign link.s_sda_oe = oe_ff;

  //////////////////////////////////////////////////////////////////////////
  // clk domain: toggles cross on two flops, third flop finds the edge
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      sync3_ff <= 2'h0;
    end else if (ce) begin
      sync1_ff <= {ptr_tgl_ff, wr_tgl_ff};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // fetch the word at the pointer; link reads it half a period later
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_en_ff <= 1'h0;
      rd_addr_ff <= 8'h0;
      rd_word_ff <= 16'h0;
    end else if (ce) begin
      rd_en_ff <= sync2_ff[1] ^ sync3_ff[1];
      if (sync2_ff[1] ^ sync3_ff[1]) begin
        rd_addr_ff <= ptr_ff;
      end
      if (rd_en_ff) begin
        rd_word_ff <= rd_data;
      end
    end
  end

  // word write strobe; hold registers are stable for many scl periods
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_en_ff <= 1'h0;
      wr_addr_ff <= 8'h0;
      wr_data_ff <= 16'h0;
    end else if (ce) begin
      wr_en_ff <= sync2_ff[0] ^ sync3_ff[0];
      if (sync2_ff[0] ^ sync3_ff[0]) begin
        wr_addr_ff <= wr_addr_hold_ff;
        wr_data_ff <= wr_hold_ff;
      end
    end
  end

  assign rd_en = rd_en_ff;
  assign rd_addr = rd_addr_ff;
  assign wr_en = wr_en_ff;
  assign wr_addr = wr_addr_ff;
  assign wr_data = wr_data_ff;

endmodule : i2c_word_slave
`default_nettype wire

/* i2c_word_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants for the word access link and its two ends
// Assumes: 20 mhz system clock on both ends
// Notes: the read-only map is a plain default, override per product
//////////////////////////////////////////////////////////////////////////////
`default_nettype none
package i2c_word_pkg;
  // slave address and direction bit
  localparam logic [6:0] SLAVE_ADDR = 7'h36;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic ACK_LEVEL = 1'h0;
  // word space
  localparam logic [7:0] TOP_PTR = 8'hff;
  localparam logic [15:0] PAST_TOP_WORD = 16'hffff;
  localparam logic [255:0] READ_ONLY_MAP = 256'h0;
  // bit positions inside one byte slot (eight data bits, then the ack)
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // master clock divider: link period in ns, quarter period in cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] SCL_QTR_LAST = 8'(SCL_QTR_CYC - 1);
endpackage : i2c_word_pkg
`default_nettype wire

/* i2c_link_if.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-wire open-drain link between master end and word slave
// Assumes: pull-ups on both wires, modelled by the inversion below
// Notes: an enable high pulls the wire low
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // wired-and of all pull-downs
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);

  modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_oe, input scl, input sda);
endinterface : i2c_link_if
`default_nettype wire

/* i2c_word_master.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-wire master issuing word writes and reads to the slave
// Assumes: no clock stretching by the slave
// Notes: scl is divided from clk, four quarter phases per bit
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module i2c_word_master (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  i2c_link_if.master link,
  input wire logic cmd_valid,
  input wire logic cmd_rw,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_words,
  output logic cmd_ready,
  input wire logic [15:0] wd_word,
  output logic wd_take,
  output logic [15:0] rd_word,
  output logic rd_valid,
  output logic done,
  output logic nack
);

  typedef enum logic [8:0] {
    M_IDLE = 9'h001,
    M_START = 9'h002,
    M_ADW = 9'h004,
    M_PTR = 9'h008,
    M_WDAT = 9'h010,
    M_RSTART = 9'h020,
    M_ADR = 9'h040,
    M_RDAT = 9'h080,
    M_STOP = 9'h100
  } ms_state_e;

  ms_state_e state_ff;
  logic [7:0] qcnt_ff;
  logic [1:0] qph_ff;
  logic [3:0] bitc_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic [8:0] bl_ff;
  logic rw_ff;
  logic [7:0] ptr_ff;
  logic hi_ff;
  logic [15:0] wbuf_ff;
  logic [7:0] lo_ff;
  logic bad_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic cmd_ready_ff;
  logic wd_take_ff;
  logic [15:0] rd_word_ff;
  logic rd_valid_ff;
  logic done_ff;
  logic nack_ff;
  logic tick;
  logic is_rx;
  logic [7:0] tx_now;

  assign tick = (qcnt_ff == i2c_word_pkg::SCL_QTR_LAST);
  assign is_rx = (state_ff == M_RDAT);

  always_comb begin
    case (state_ff)
      M_ADW: tx_now = {i2c_word_pkg::SLAVE_ADDR, i2c_word_pkg::DIR_WRITE};
      M_PTR: tx_now = ptr_ff;
      M_ADR: tx_now = {i2c_word_pkg::SLAVE_ADDR, i2c_word_pkg::DIR_READ};
      M_WDAT: tx_now = hi_ff ? wbuf_ff[15:8] : wd_word[7:0];
      default: tx_now = 8'hff;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sda comes back from the wire: two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_s1_ff <= 1'h1;
      sda_s2_ff <= 1'h1;
    end else if (ce) begin
      sda_s1_ff <= link.sda;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  // quarter-period divider, held while idle
  always_ff @(posedge clk) begin
    if (rst) begin
      qcnt_ff <= 8'h0;
    end else if (ce) begin
      if (state_ff == M_IDLE || tick) begin
        qcnt_ff <= 8'h0;
      end else begin
        qcnt_ff <= qcnt_ff + 8'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= M_IDLE;
      qph_ff <= 2'h0;
      bitc_ff <= 4'h0;
      tx_ff <= 8'h0;
      rx_ff <= 8'h0;
      bl_ff <= 9'h0;
      rw_ff <= 1'h0;
      ptr_ff <= 8'h0;
      hi_ff <= 1'h0;
      wbuf_ff <= 16'h0;
      lo_ff <= 8'h0;
      bad_ff <= 1'h0;
      scl_oe_ff <= 1'h0;
      sda_oe_ff <= 1'h0;
      cmd_ready_ff <= 1'h1;
      wd_take_ff <= 1'h0;
      rd_word_ff <= 16'h0;
      rd_valid_ff <= 1'h0;
      done_ff <= 1'h0;
      nack_ff <= 1'h0;
    end else if (ce) begin
      wd_take_ff <= 1'h0;
      rd_valid_ff <= 1'h0;
      done_ff <= 1'h0;
      if (state_ff == M_IDLE) begin
        if (cmd_valid && cmd_ready_ff) begin
          state_ff <= M_START;
          cmd_ready_ff <= 1'h0;
          rw_ff <= cmd_rw;
          ptr_ff <= cmd_ptr;
          bl_ff <= {cmd_words, 1'h0};
          hi_ff <= 1'h0;
          bad_ff <= 1'h0;
          nack_ff <= 1'h0;
          qph_ff <= 2'h0;
          bitc_ff <= 4'h0;
        end
      end else if (tick) begin
        qph_ff <= qph_ff + 2'h1;
        if (state_ff == M_START || state_ff == M_RSTART) begin
          case (qph_ff)
            2'h0: sda_oe_ff <= 1'h0;
            2'h1: scl_oe_ff <= 1'h0;
            2'h2: sda_oe_ff <= 1'h1;
            default: begin
              scl_oe_ff <= 1'h1;
              state_ff <= (state_ff == M_START) ? M_ADW : M_ADR;
            end
          endcase
        end else if (state_ff == M_STOP) begin
          case (qph_ff)
            2'h0: sda_oe_ff <= 1'h1;
            2'h1: scl_oe_ff <= 1'h0;
            2'h2: sda_oe_ff <= 1'h0;
            default: begin
              state_ff <= M_IDLE;
              cmd_ready_ff <= 1'h1;
              done_ff <= 1'h1;
            end
          endcase
        end else begin
          case (qph_ff)
            2'h0: begin
              if (bitc_ff == i2c_word_pkg::BIT_ACK) begin
                // ack every read byte except the last one
                sda_oe_ff <= is_rx && (bl_ff != 9'h1);
              end else if (is_rx) begin
                sda_oe_ff <= 1'h0;
              end else if (bitc_ff == 4'h0) begin
                tx_ff <= tx_now;
                sda_oe_ff <= ~tx_now[7];
                if (state_ff == M_WDAT && !hi_ff) begin
                  wbuf_ff <= wd_word;
                  wd_take_ff <= 1'h1;
                end
              end else begin
                sda_oe_ff <= ~tx_ff[~bitc_ff[2:0]];
              end
            end
            2'h1: scl_oe_ff <= 1'h0;
            2'h2: begin
              if (bitc_ff != i2c_word_pkg::BIT_ACK) begin
                rx_ff <= {rx_ff[6:0], sda_s2_ff};
              end else if (!is_rx && sda_s2_ff != i2c_word_pkg::ACK_LEVEL) begin
                bad_ff <= 1'h1;
              end
            end
            default: begin
              scl_oe_ff <= 1'h1;
              if (bitc_ff != i2c_word_pkg::BIT_ACK) begin
                bitc_ff <= bitc_ff + 4'h1;
              end else begin
                bitc_ff <= 4'h0;
                if (bad_ff) begin
                  nack_ff <= 1'h1;
                  state_ff <= M_STOP;
                end else begin
                  case (state_ff)
                    M_ADW: state_ff <= M_PTR;
                    M_PTR: begin
                      if (bl_ff == 9'h0) begin
                        state_ff <= M_STOP;
                      end else begin
                        state_ff <= rw_ff ? M_RSTART : M_WDAT;
                      end
                    end
                    M_ADR: state_ff <= M_RDAT;
                    M_WDAT, M_RDAT: begin
                      hi_ff <= ~hi_ff;
                      bl_ff <= bl_ff - 9'h1;
                      if (is_rx && !hi_ff) begin
                        lo_ff <= rx_ff;
                      end
                      if (is_rx && hi_ff) begin
                        rd_word_ff <= {rx_ff, lo_ff};
                        rd_valid_ff <= 1'h1;
                      end
                      if (bl_ff == 9'h1) begin
                        state_ff <= M_STOP;
                      end
                    end
                    default: state_ff <= M_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
    end
  end

  assign link.m_scl_oe = scl_oe_ff;
  assign link.m_sda_oe = sda_oe_ff;
  assign cmd_ready = cmd_ready_ff;
  assign wd_take = wd_take_ff;
  assign rd_word = rd_word_ff;
  assign rd_valid = rd_valid_ff;
  assign done = done_ff;
  assign nack = nack_ff;

endmodule : i2c_word_master
`default_nettype wire

/* i2c_word_props.sv */
// Purpose: protocol checks on the two-wire link between the ends
// Assumes: scl and sda sampled on clk, scl far slower than clk
// Notes: bit slots are counted from each start; slot 8 is the ack
`timescale 1ns/1ps
`default_nettype none
module i2c_word_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_ff, sda_ff, act_ff, dir_ff;
  logic [3:0] slot_ff;
  logic [1:0] byte_ff;
  wire logic start_w = scl & scl_ff & sda_ff & ~sda;
  wire logic stop_w = scl & scl_ff & ~sda_ff & sda;
  wire logic rise_w = scl & ~scl_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    scl_ff <= rst | scl;
    sda_ff <= rst | sda;
  end
  always_ff @(posedge clk) begin
    if (rst || stop_w) act_ff <= 1'h0;
    else if (start_w) act_ff <= 1'h1;
  end
  // byte count saturates: only address, first byte, later bytes matter
  always_ff @(posedge clk) begin
    if (rst || start_w) begin
      slot_ff <= 4'h0;
      byte_ff <= 2'h0;
    end else if (rise_w) begin
      slot_ff <= (slot_ff == 4'h8) ? 4'h0 : slot_ff + 4'h1;
      if (slot_ff == 4'h8 && byte_ff != 2'h2) byte_ff <= byte_ff + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) dir_ff <= 1'h0;
    else if (rise_w && slot_ff == 4'h7 && byte_ff == 2'h0) dir_ff <= sda;
  end
  //////////////////////////////////////////////////////////////////////////
  sequence s_ack_rise;
    rise_w && slot_ff == 4'h8 && !sda;
  endsequence
  sequence s_rd_nack;
    rise_w && slot_ff == 4'h8 && dir_ff && byte_ff != 2'h0 && sda;
  endsequence
  chk_addr_ack: assert property (
    rise_w && slot_ff == 4'h8 && byte_ff == 2'h0 && act_ff |-> !sda)
    else $error("address not acked");
  chk_write_acks: assert property (
    rise_w && slot_ff == 4'h8 && act_ff && !dir_ff |-> !sda)
    else $error("write byte not acked");
  chk_bus_quiet: assert property (
    !act_ff || (byte_ff == 2'h0 && slot_ff < 4'h8) |-> !s_sda_oe)
    else $error("slave drives outside its slots");
  chk_slave_stable: assert property (
    scl && scl_ff |-> $stable(s_sda_oe))
    else $error("slave sda moved while scl high");
  chk_rd_master_quiet: assert property (
    rise_w && dir_ff && byte_ff != 2'h0 && slot_ff inside {[1:7]}
    |-> !m_sda_oe) else $error("master drives read data bit");
  chk_wr_slave_quiet: assert property (
    rise_w && !dir_ff && byte_ff != 2'h0 && slot_ff < 4'h8 |-> !s_sda_oe)
    else $error("slave drives write data bit");
  chk_rd_nack_end: assert property (
    s_rd_nack |-> ##[1:600] stop_w) else $error("no stop after nack");
  chk_ack_hold: assert property (
    s_ack_rise |=> !sda [*8]) else $error("ack released early");
endmodule : i2c_word_props
`default_nettype wire

/* test_i2c_word_register_access_slave.sv */
// Purpose: end to end test of word writes and reads over the link
// Assumes: both ends on one 20 mhz clock, scl made by the master
// Notes: scl period is fixed in the package, so frames stay few
`timescale 1ns/1ps
`default_nettype none
module test_i2c_word_register_access_slave;
  logic clk = 1'h0;
  logic rst;
  logic cmd_valid = 1'h0;
  logic cmd_rw = 1'h0;
  logic [7:0] cmd_ptr = 8'h0;
  logic [7:0] cmd_words = 8'h0;
  logic cmd_ready, wd_take, rd_valid, done, nack, rd_en, wr_en;
  logic [7:0] rd_addr, wr_addr;
  logic [15:0] wd_word, rd_word, wr_data;
  logic [15:0] rd_data;
  logic [15:0] mem [256];
  logic [15:0] wq [2];
  logic [15:0] rq [$];
  int wi = 0;
  int wcnt = 0;
  int rcnt = 0;
  int failures = 0;
  int n_tests = 0;
  i2c_link_if link ();
  always #25 clk = ~clk;
  assign wd_word = wq[wi % 2];
  i2c_word_master i_i2c_word_master (.clk(clk), .rst(rst), .ce(1'h1),
    .link(link), .cmd_valid(cmd_valid), .cmd_rw(cmd_rw),
    .cmd_ptr(cmd_ptr), .cmd_words(cmd_words), .cmd_ready(cmd_ready),
    .wd_word(wd_word), .wd_take(wd_take), .rd_word(rd_word),
    .rd_valid(rd_valid), .done(done), .nack(nack));
  i2c_word_slave i_i2c_word_slave (.clk(clk), .rst(rst), .ce(1'h1),
    .link(link), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  i2c_word_props u_props (.clk(clk), .rst(rst),
    .m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe),
    .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));
  // word space: read data must stand at the edge after rd_en, so the
  // lookup is combinational on rd_addr
  assign rd_data = mem[rd_addr];
  always @(posedge clk) begin
    if (rd_en) rcnt <= rcnt + 1;
    if (wr_en) mem[wr_addr] <= wr_data;
    if (wr_en) wcnt <= wcnt + 1;
    if (wd_take) wi <= wi + 1;
    if (rd_valid) rq.push_back(rd_word);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input logic rw, input logic [7:0] p,
      input logic [7:0] n);
    int k;
    rq.delete();
    wi = 0;
    wcnt = 0;
    rcnt = 0;
    @(posedge clk);
    cmd_rw <= rw;
    cmd_ptr <= p;
    cmd_words <= n;
    cmd_valid <= 1'h1;
    @(posedge clk);
    cmd_valid <= 1'h0;
    for (k = 0; k < 20000; k++) begin
      @(posedge clk);
      #1;
      if (done === 1'h1) break;
    end
    check(16'(done), 16'h1);
    check(16'(cmd_ready), 16'h1);
    check(16'(nack), 16'h0);
  endtask : run
  task automatic t_write_run();
    wq[0] = 16'h1234;
    wq[1] = 16'habcd;
    run(1'h0, 8'h10, 8'h2);
    check(mem[8'h10], 16'h1234);
    check(mem[8'h11], 16'habcd);
    check(16'(wcnt), 16'h2);
    $display("done: write run");
  endtask : t_write_run
  task automatic t_read_run();
    run(1'h1, 8'h10, 8'h2);
    check(16'(rq.size()), 16'h2);
    check(16'(rcnt), 16'h2);
    check(rq[0], 16'h1234);
    check(rq[1], 16'habcd);
    $display("done: read run");
  endtask : t_read_run
  task automatic t_top_edge();
    wq[0] = 16'h5a5a;
    wq[1] = 16'h0f0f;
    run(1'h0, 8'hff, 8'h2);
    check(mem[8'hff], 16'h5a5a);
    check(mem[8'h00], 16'h0000);
    check(16'(wcnt), 16'h1);
    run(1'h1, 8'hff, 8'h2);
    check(rq[0], 16'h5a5a);
    check(rq[1], 16'hffff);
    check(16'(rcnt), 16'h1);
    $display("done: top address");
  endtask : t_top_edge
  task automatic t_pointer_only();
    run(1'h0, 8'h20, 8'h0);
    check(16'(wcnt), 16'h0);
    run(1'h1, 8'h11, 8'h1);
    check(16'(rq.size()), 16'h1);
    check(rq[0], 16'habcd);
    $display("done: pointer only");
  endtask : t_pointer_only
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    // a real rising edge on rst clears the link-side async flops
    rst <= 1'h1;
    for (int i = 0; i < 256; i++) mem[i] = 16'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_write_run();
    t_read_run();
    t_top_edge();
    t_pointer_only();
    summarize();
  end
  // frames take about 62k cycles in all, so this leaves ample margin
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : test_i2c_word_register_access_slave
`default_nettype wire
